// ---- sim/cptg_load.sv ----
`timescale 1ns/1ns
// ****************************************
// Channel load model
// ****************************************
// The load only sees a level, so it measures each phase in clock cycles
// and counts active pulses. A final inactive phase has no closing edge,
// so its length is never recorded.
module cptg_load (
	input  wire logic clock_in,
	input  wire logic rst_in,
	input  wire logic chan_in,
	output int        pulses_out,
	output int        high_len_out,
	output int        low_len_out
);
	int   run;
	logic last;

	// Phase lengths are latched at each level change of the channel.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			pulses_out   <= 0;
			high_len_out <= 0;
			low_len_out  <= 0;
			run          <= 0;
			last         <= 1'b0;
		end else begin
			last <= chan_in;
			if (chan_in != last) begin
				run <= 1;
				if (chan_in) begin
					pulses_out  <= pulses_out + 1;
					low_len_out <= run;
				end else begin
					high_len_out <= run;
				end
			end else begin
				run <= run + 1;
			end
		end
	end
endmodule : cptg_load

// ---- sim/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	import cptg_pkg::*;
	localparam int U = 4;
	logic        clock_in = 1'b0;
	logic        rst_in   = 1'b1;
	logic [3:0]  addr     = 4'h0;
	logic [31:0] wdata    = 32'h0;
	logic        wr       = 1'b0;
	logic        rd       = 1'b0;
	logic [31:0] rdata;
	logic        chan;
	logic        busy;
	int          pulses, high_len, low_len, p0, n, cyc;
	int          fail_count  = 0;
	int          comparisons = 0;
	// Start requests under manual, manual again and FUNC_DLY_I2A; each sees the function set before its own write.
	logic [31:0] p0_list [3] = '{32'h8, 32'hA, 32'hB};

	// A short unit keeps every phase a few cycles long.
	cptg_top #(.UNIT_CYCLES(U)) i_dut (.clock_in(clock_in), .rst_in(rst_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .chan_out(chan), .busy_out(busy));
	cptg_load i_load (.clock_in(clock_in), .rst_in(rst_in), .chan_in(chan),
		.pulses_out(pulses), .high_len_out(high_len), .low_len_out(low_len));

	initial begin
		forever #5 clock_in = ~clock_in;
	end

	// ****************************************
	// Bus tasks and checks
	// ****************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk

	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clock_in);
		wr    <= 1'b0;
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe, so sample there.
	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock_in);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock_in);
		rd   <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask : rd_chk

	// Counts the clock periods from the start edge to the edge that ends the train.
	task run_train(input int exp_cycles);
		n = 0;
		#1;
		while (busy === 1'b1 && n < 2000) begin
			n++;
			@(posedge clock_in);
			#1;
		end
		chk(n, exp_cycles);
		chk(chan, 1'b0);
	endtask : run_train

	task finish_test;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	// A hang is cut short well beyond the length of the whole sequence.
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			finish_test();
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clock_in);
		rst_in <= 1'b0;
		rd_chk(ADDR_COUNT, 32'h1);
		rd_chk(ADDR_ACT_W, 32'h1);
		rd_chk(ADDR_INACT_W, 32'h1);
		rd_chk(ADDR_CTRL, 32'h0);
		rd_chk(4'hF, 32'h0);
		// Starts under non-pulse functions must not pulse.
		foreach (p0_list[i]) begin
			wr_reg(ADDR_CTRL, p0_list[i]);
			repeat (10) @(posedge clock_in);
			#1;
			chk({busy, chan}, 2'b00);
		end
		wr_reg(ADDR_CTRL, 32'h5);
		repeat (10) @(posedge clock_in);
		#1;
		chk({busy, chan}, 2'b00);
		// Default count and widths: one cycle of one unit each.
		wr_reg(ADDR_CTRL, 32'hD);
		run_train(2 * U);
		rd_chk(ADDR_DONE_CNT, 32'h0);
		wr_reg(ADDR_ACT_W, 32'h0);
		rd_chk(ADDR_ACT_W, 32'h1);
		wr_reg(ADDR_INACT_W, 32'h3FFF);
		rd_chk(ADDR_INACT_W, 32'h270F);
		wr_reg(ADDR_ACT_W, 32'h2);
		wr_reg(ADDR_INACT_W, 32'h3);
		wr_reg(ADDR_COUNT, 32'h3);
		p0 = pulses;
		wr_reg(ADDR_CTRL, 32'hD);
		run_train(3 * 5 * U);
		chk(pulses - p0, 3);
		chk(high_len, 2 * U);
		chk(low_len, 3 * U);
		// Continuous mode keeps going past any count.
		p0 = pulses;
		wr_reg(ADDR_CTRL, 32'h9);
		repeat (100) @(posedge clock_in);
		#1;
		chk(pulses - p0, 5);
		chk(busy, 1'b1);
		rd_chk(ADDR_DONE_CNT, 32'h5);
		rd_chk(ADDR_STATUS, 32'h5);
		wr_reg(ADDR_CTRL, 32'h11);
		@(posedge clock_in);
		#1;
		chk({busy, chan}, 2'b00);
		rd_chk(ADDR_DONE_CNT, 32'h0);
		rd_chk(ADDR_STATUS, 32'h0);
		// A counted start with a zero count is ignored; mode is set a write earlier.
		wr_reg(ADDR_COUNT, 32'h0);
		wr_reg(ADDR_CTRL, 32'h5);
		wr_reg(ADDR_CTRL, 32'hD);
		@(posedge clock_in);
		#1;
		chk({busy, chan}, 2'b00);
		finish_test();
	end
endmodule : testbench

// ---- verilog/cptg_pkg.sv ----
// Functional notes
// - The continuous or counted pulse shape only matters while the output function is pulse.
// - Continuous mode alternates active and inactive phases forever and is the reset default.
// - Counted mode emits exactly the programmed number of cycles and then stops.
// - One count is one active phase followed by one inactive phase; the count defaults to 1.
// - The inactive phase lasts the programmed width of 1 to 9999 units of 100 ms, default 1.
// - The active phase lasts the programmed width of 1 to 9999 units of 100 ms, default 1.
// - Pulsing starts only after the channel is manually activated.
package cptg_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0]  ADDR_CTRL      = 4'h0;
	localparam logic [3:0]  ADDR_COUNT     = 4'h1;
	localparam logic [3:0]  ADDR_ACT_W     = 4'h2;
	localparam logic [3:0]  ADDR_INACT_W   = 4'h3;
	localparam logic [3:0]  ADDR_STATUS    = 4'h4;
	localparam logic [3:0]  ADDR_DONE_CNT  = 4'h5;

	// Control field positions.
	localparam int          CTRL_FUNC_LSB  = 0;
	localparam int          CTRL_MODE_BIT  = 2;
	localparam int          CTRL_START_BIT = 3;
	localparam int          CTRL_STOP_BIT  = 4;

	// ****************************************
	// Encodings and reset values
	// ****************************************
	typedef enum logic [1:0] {
		FUNC_MANUAL   = 2'b00,
		FUNC_PULSE    = 2'b01,
		FUNC_DLY_I2A  = 2'b10,
		FUNC_DLY_A2I  = 2'b11
	} cptg_func_t;

	typedef enum logic {
		MODE_CONT  = 1'b0,
		MODE_COUNT = 1'b1
	} cptg_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_ACTIVE   = 2'b01,
		ST_INACTIVE = 2'b10
	} cptg_state_t;

	localparam logic [15:0] COUNT_RST      = 16'h0001;
	localparam logic [13:0] WIDTH_RST      = 14'h0001;
	localparam logic [13:0] WIDTH_MIN      = 14'h0001;
	localparam logic [13:0] WIDTH_MAX      = 14'h270F;

	// ****************************************
	// Timing
	// ****************************************
	localparam int          CLK_MHZ        = 100;
	localparam int          UNIT_MS        = 100;
	localparam int          UNIT_CYCLES    = UNIT_MS * 1000 * CLK_MHZ;

endpackage : cptg_pkg

// ---- verilog/cptg_regs.sv ----
`timescale 1ns/1ns
// Settings held by software; widths are clamped into their legal range on write.
module cptg_regs (
	input  wire logic                  clock_in,
	input  wire logic                  rst_in,
	input  wire logic [3:0]            addr_in,
	input  wire logic [31:0]           wdata_in,
	input  wire logic                  wr_in,
	output cptg_pkg::cptg_func_t       func_out,
	output cptg_pkg::cptg_mode_t       mode_out,
	output logic [15:0]                count_out,
	output logic [13:0]                act_w_out,
	output logic [13:0]                inact_w_out
);
	import cptg_pkg::*;

	cptg_func_t  next_func;
	cptg_mode_t  next_mode;
	logic [15:0] next_count;
	logic [13:0] next_act;
	logic [13:0] next_inact;

	function automatic logic [13:0] clamp_w(input logic [31:0] v);
		logic [13:0] r;
		r = v[13:0];
		if (v[31:0] < 32'(WIDTH_MIN)) r = WIDTH_MIN;
		else if (v[31:0] > 32'(WIDTH_MAX)) r = WIDTH_MAX;
		return r;
	endfunction : clamp_w

	// Write decode.
	always_comb begin
		next_func  = func_out;
		next_mode  = mode_out;
		next_count = count_out;
		next_act   = act_w_out;
		next_inact = inact_w_out;
		if (wr_in && addr_in == ADDR_CTRL) begin
			next_func = cptg_func_t'(wdata_in[CTRL_FUNC_LSB +: 2]);
			next_mode = cptg_mode_t'(wdata_in[CTRL_MODE_BIT]);
		end else if (wr_in && addr_in == ADDR_COUNT) begin
			next_count = wdata_in[15:0];
		end else if (wr_in && addr_in == ADDR_ACT_W) begin
			next_act = clamp_w(wdata_in);
		end else if (wr_in && addr_in == ADDR_INACT_W) begin
			next_inact = clamp_w(wdata_in);
		end
	end

	// Register the settings; defaults match the documented ones.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			func_out    <= FUNC_MANUAL;
			mode_out    <= MODE_CONT;
			count_out   <= COUNT_RST;
			act_w_out   <= WIDTH_RST;
			inact_w_out <= WIDTH_RST;
		end else begin
			func_out    <= next_func;
			mode_out    <= next_mode;
			count_out   <= next_count;
			act_w_out   <= next_act;
			inact_w_out <= next_inact;
		end
	end

endmodule : cptg_regs

// ---- verilog/cptg_tick_div.sv ----
`timescale 1ns/1ns
// Divides the system clock down to one enable pulse per 100 ms unit.
module cptg_tick_div #(
	parameter int UNIT_CYCLES = cptg_pkg::UNIT_CYCLES
) (
	input  wire logic  clock_in,
	input  wire logic  rst_in,
	cptg_tick_if.src   tick_bus
);
	import cptg_pkg::*;

	logic [31:0] div_cnt;
	logic [31:0] next_div_cnt;
	logic        next_tick;

	// Restart on clear so that every phase begins on a full unit.
	always_comb begin
		next_div_cnt = div_cnt + 32'h00000001;
		next_tick    = 1'b0;
		if (tick_bus.clear) begin
			next_div_cnt = 32'h00000000;
		end else if (div_cnt >= 32'(UNIT_CYCLES - 1)) begin
			next_div_cnt = 32'h00000000;
			next_tick    = 1'b1;
		end
	end

	// Register the count and the tick.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			div_cnt       <= 32'h00000000;
			tick_bus.tick <= 1'b0;
		end else begin
			div_cnt       <= next_div_cnt;
			tick_bus.tick <= next_tick;
		end
	end

endmodule : cptg_tick_div

// ---- verilog/cptg_tick_if.sv ----
`timescale 1ns/1ns
// Timebase tick and its clear, shared between the top and the divider.
interface cptg_tick_if;
	logic tick;
	logic clear;
	modport src (output tick, input clear);
	modport dst (input tick, output clear);
endinterface : cptg_tick_if

// ---- verilog/cptg_top.sv ----
`timescale 1ns/1ns
// Pulse train generator for one output channel.
module cptg_top #(
	parameter int UNIT_CYCLES = cptg_pkg::UNIT_CYCLES
) (
	input  wire logic         clock_in,
	input  wire logic         rst_in,
	input  wire logic [3:0]   addr_in,
	input  wire logic [31:0]  wdata_in,
	input  wire logic         wr_in,
	input  wire logic         rd_in,
	output logic [31:0]       rdata_out,
	output logic              chan_out,
	output logic              busy_out
);
	import cptg_pkg::*;

	cptg_tick_if tick_bus ();
	cptg_func_t  func;
	cptg_mode_t  mode;
	logic [15:0] count_set;
	logic [13:0] act_w;
	logic [13:0] inact_w;

	cptg_state_t state;
	cptg_state_t next_state;
	logic [13:0] phase_cnt;
	logic [13:0] next_phase_cnt;
	logic [15:0] cyc_cnt;
	logic [15:0] next_cyc_cnt;
	logic        next_chan;
	logic [31:0] next_rdata;
	logic        start_req;
	logic        stop_req;
	logic        counted;
	logic [31:0] tick_gap;
	logic [31:0] next_tick_gap;

	// ****************************************
	// Settings and timebase
	// ****************************************
	cptg_regs u_regs (
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.addr_in     (addr_in),
		.wdata_in    (wdata_in),
		.wr_in       (wr_in),
		.func_out    (func),
		.mode_out    (mode),
		.count_out   (count_set),
		.act_w_out   (act_w),
		.inact_w_out (inact_w)
	);

	cptg_tick_div #(.UNIT_CYCLES(UNIT_CYCLES)) u_div (
		.clock_in (clock_in),
		.rst_in   (rst_in),
		.tick_bus (tick_bus.src)
	);

	// Start and stop are write-only strobes in the control word.
	assign start_req = wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_START_BIT];
	assign stop_req  = wr_in && addr_in == ADDR_CTRL && wdata_in[CTRL_STOP_BIT];
	// Mode only matters under the pulse function.
	assign counted   = (func == FUNC_PULSE) && (mode == MODE_COUNT);
	// Hold the divider at zero whenever no train runs in the next cycle.
	// Releasing it on the start edge itself keeps the first unit as long as the rest.
	assign tick_bus.clear = (next_state == ST_IDLE);
	assign busy_out  = (state != ST_IDLE);

	// ****************************************
	// Phase sequencer
	// ****************************************
	// Phase counters count ticks; a phase ends after its width in ticks.
	always_comb begin
		next_state     = state;
		next_phase_cnt = phase_cnt;
		next_cyc_cnt   = cyc_cnt;
		case (state)
			ST_IDLE: begin
				next_phase_cnt = 14'h0000;
				next_cyc_cnt   = 16'h0000;
				// A zero count in counted mode produces nothing.
				if (start_req && !stop_req && func == FUNC_PULSE &&
				    !(counted && count_set == 16'h0000)) begin
					next_state = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (tick_bus.tick) begin
					if (phase_cnt + 14'h0001 >= act_w) begin
						next_state     = ST_INACTIVE;
						next_phase_cnt = 14'h0000;
					end else begin
						next_phase_cnt = phase_cnt + 14'h0001;
					end
				end
			end
			ST_INACTIVE: begin
				if (tick_bus.tick) begin
					if (phase_cnt + 14'h0001 >= inact_w) begin
						next_phase_cnt = 14'h0000;
						next_cyc_cnt   = cyc_cnt + 16'h0001;
						if (counted && cyc_cnt + 16'h0001 >= count_set) begin
							next_state   = ST_IDLE;
							next_cyc_cnt = 16'h0000;
						end else begin
							next_state = ST_ACTIVE;
						end
					end else begin
						next_phase_cnt = phase_cnt + 14'h0001;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// Deactivation or leaving the pulse function ends the train at once.
		if (state != ST_IDLE && (stop_req || func != FUNC_PULSE)) begin
			next_state     = ST_IDLE;
			next_phase_cnt = 14'h0000;
			next_cyc_cnt   = 16'h0000;
		end
		next_chan = (next_state == ST_ACTIVE);
	end

	// Register the sequencer; the output is registered to stay glitch free.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state     <= ST_IDLE;
			phase_cnt <= 14'h0000;
			cyc_cnt   <= 16'h0000;
			chan_out  <= 1'b0;
		end else begin
			state     <= next_state;
			phase_cnt <= next_phase_cnt;
			cyc_cnt   <= next_cyc_cnt;
			chan_out  <= next_chan;
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Unmapped addresses read as zero.
	always_comb begin
		next_rdata = 32'h00000000;
		if (!rd_in) begin
			next_rdata = 32'h00000000;
		end else if (addr_in == ADDR_CTRL) begin
			next_rdata = {29'h00000000, mode, func};
		end else if (addr_in == ADDR_COUNT) begin
			next_rdata = {16'h0000, count_set};
		end else if (addr_in == ADDR_ACT_W) begin
			next_rdata = {18'h00000, act_w};
		end else if (addr_in == ADDR_INACT_W) begin
			next_rdata = {18'h00000, inact_w};
		end else if (addr_in == ADDR_STATUS) begin
			next_rdata = {29'h00000000, chan_out, state};
		end else if (addr_in == ADDR_DONE_CNT) begin
			next_rdata = {16'h0000, cyc_cnt};
		end
	end

	// Read data stand for the one cycle after the strobe.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_out <= 32'h00000000;
		end else begin
			rdata_out <= next_rdata;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_NO_START: assert property (@(posedge clock_in) disable iff (rst_in)
		$rose(chan_out) |-> $past(state) != ST_IDLE || $past(start_req))
		else $error("Output went active without a start.");
	AST_IDLE_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
		state == ST_IDLE |-> !chan_out && phase_cnt == 14'h0000 && cyc_cnt == 16'h0000)
		else $error("Idle with output or counters not cleared.");
	AST_STOP: assert property (@(posedge clock_in) disable iff (rst_in)
		stop_req |=> state == ST_IDLE)
		else $error("Stop did not end the train.");
	AST_FUNC: assert property (@(posedge clock_in) disable iff (rst_in)
		func != FUNC_PULSE |=> !chan_out)
		else $error("Output pulsed outside pulse function.");
	AST_ACT_W: assert property (@(posedge clock_in) disable iff (rst_in)
		state == ST_ACTIVE && tick_bus.tick && phase_cnt + 14'h0001 < act_w
		&& !stop_req && func == FUNC_PULSE |=> state == ST_ACTIVE)
		else $error("Active phase ended early.");
	AST_INACT_W: assert property (@(posedge clock_in) disable iff (rst_in)
		state == ST_INACTIVE && tick_bus.tick && phase_cnt + 14'h0001 < inact_w
		&& !stop_req && func == FUNC_PULSE |=> state == ST_INACTIVE)
		else $error("Inactive phase ended early.");
	AST_CONT: assert property (@(posedge clock_in) disable iff (rst_in)
		state == ST_INACTIVE && !counted && func == FUNC_PULSE && !stop_req
		|=> state != ST_IDLE)
		else $error("Continuous train stopped by itself.");
	AST_COUNT: assert property (@(posedge clock_in) disable iff (rst_in)
		state != ST_IDLE && counted |-> cyc_cnt < count_set)
		else $error("Counted train ran past its count.");
	AST_CYC: assert property (@(posedge clock_in) disable iff (rst_in)
		$past(state) == ST_INACTIVE && state == ST_ACTIVE
		|-> cyc_cnt == $past(cyc_cnt) + 16'h0001)
		else $error("Cycle not counted on a full period.");

	// ****************************************
	// Timebase and sequence checks
	// ****************************************
	// Cycles since the divider restarted or last ticked, kept only for the checks.
	// It measures the unit apart from the divider, so a skewed first unit shows up.
	always_comb begin
		next_tick_gap = tick_gap + 32'h00000001;
		if (tick_bus.clear) begin
			next_tick_gap = 32'h00000000;
		end else if (tick_bus.tick) begin
			next_tick_gap = 32'h00000001;
		end
	end

	// Register the helper count.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			tick_gap <= 32'h00000000;
		end else begin
			tick_gap <= next_tick_gap;
		end
	end

	// A start that the sequencer has to take.
	sequence s_start_ok;
		state == ST_IDLE && start_req && !stop_req && func == FUNC_PULSE
		&& !(counted && count_set == 16'h0000);
	endsequence

	// The first active phase opens with both counters cleared.
	sequence s_first_phase;
		state == ST_ACTIVE && chan_out && phase_cnt == 14'h0000 && cyc_cnt == 16'h0000;
	endsequence

	// Idle with no start under the pulse function.
	sequence s_idle_wait;
		state == ST_IDLE && !(start_req && func == FUNC_PULSE);
	endsequence

	// A counted start with a zero count.
	sequence s_zero_count;
		state == ST_IDLE && start_req && counted && count_set == 16'h0000;
	endsequence

	// The last tick of an active phase.
	sequence s_act_end;
		state == ST_ACTIVE && tick_bus.tick && phase_cnt + 14'h0001 >= act_w
		&& func == FUNC_PULSE && !stop_req;
	endsequence

	// The last tick of an inactive phase that closes the final counted cycle.
	sequence s_last_cycle;
		state == ST_INACTIVE && tick_bus.tick && phase_cnt + 14'h0001 >= inact_w
		&& func == FUNC_PULSE && !stop_req && counted && cyc_cnt + 16'h0001 >= count_set;
	endsequence

	// The last tick of an inactive phase that another cycle follows.
	sequence s_next_cycle;
		state == ST_INACTIVE && tick_bus.tick && phase_cnt + 14'h0001 >= inact_w
		&& func == FUNC_PULSE && !stop_req && !(counted && cyc_cnt + 16'h0001 >= count_set);
	endsequence

	// A running train between two ticks.
	sequence s_between_ticks;
		state != ST_IDLE && !tick_bus.tick && func == FUNC_PULSE && !stop_req;
	endsequence

	// A running train told to stop, or moved off the pulse function.
	sequence s_halt;
		state != ST_IDLE && (stop_req || func != FUNC_PULSE);
	endsequence

	// Each property below except the unit check ties one step of the train to the cycle after it.
	// The unit check keeps every timebase unit exactly UNIT_CYCLES clock cycles long.
	AST_UNIT: assert property (@(posedge clock_in) disable iff (rst_in)
		tick_bus.tick |-> tick_gap == 32'(UNIT_CYCLES))
		else $error("Timebase unit has the wrong length.");
	AST_START: assert property (@(posedge clock_in) disable iff (rst_in)
		s_start_ok |=> s_first_phase)
		else $error("Accepted start did not open an active phase.");
	AST_IDLE_WAIT: assert property (@(posedge clock_in) disable iff (rst_in)
		s_idle_wait |=> state == ST_IDLE && !chan_out)
		else $error("Train began without a start.");
	AST_ZERO: assert property (@(posedge clock_in) disable iff (rst_in)
		s_zero_count |=> state == ST_IDLE)
		else $error("Zero count started a train.");
	AST_ACT_END: assert property (@(posedge clock_in) disable iff (rst_in)
		s_act_end |=> state == ST_INACTIVE && !chan_out && phase_cnt == 14'h0000)
		else $error("Active phase did not end on time.");
	AST_LAST: assert property (@(posedge clock_in) disable iff (rst_in)
		s_last_cycle |=> state == ST_IDLE && !chan_out && cyc_cnt == 16'h0000)
		else $error("Counted train did not stop after its last cycle.");
	AST_NEXT: assert property (@(posedge clock_in) disable iff (rst_in)
		s_next_cycle |=> state == ST_ACTIVE && chan_out && cyc_cnt == $past(cyc_cnt) + 16'h0001)
		else $error("Next cycle did not start or was not counted.");
	AST_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
		s_between_ticks |=> $stable(state) && $stable(phase_cnt))
		else $error("Phase moved without a timebase tick.");
	AST_HALT: assert property (@(posedge clock_in) disable iff (rst_in)
		s_halt |=> state == ST_IDLE && !chan_out && phase_cnt == 14'h0000 && cyc_cnt == 16'h0000)
		else $error("Stopped train left output or counters set.");

endmodule : cptg_top
